// [bcsp_pkg.sv]
// constants shared by the bridge control and status pin block
package bcsp_pkg;

    // ********************************
    // clock and timing
    // ********************************
    localparam int CLK_PERIOD_PS = 10000;
    localparam int MEDIA_FILTER_NS = 10000;
    localparam int MEDIA_FILTER_CYCLES = (MEDIA_FILTER_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // ********************************
    // register byte offsets
    // ********************************
    localparam logic [4:0] CTRL_OFFSET = 5'h00;
    localparam logic [4:0] STATUS_OFFSET = 5'h04;
    localparam logic [4:0] GPIO_OUT_OFFSET = 5'h08;
    localparam logic [4:0] GPIO_DIR_OFFSET = 5'h0c;
    localparam logic [4:0] GPIO_IN_OFFSET = 5'h10;
    localparam logic [4:0] IRQ_STATUS_OFFSET = 5'h14;
    localparam logic [4:0] IRQ_MASK_OFFSET = 5'h18;

    // ********************************
    // control fields and reset values
    // ********************************
    localparam int CTRL_W = 4;
    localparam int CTRL_WAKE_EN_BIT = 0;
    localparam int CTRL_DRV_FEATURE_BIT = 1;
    localparam int CTRL_DRV_POL_BIT = 2;
    localparam int CTRL_LOW_POWER_BIT = 3;
    localparam logic [3:0] CTRL_RESET = 4'h0;
    localparam logic [9:0] GPIO_OUT_RESET = 10'h000;
    localparam logic [9:0] GPIO_DIR_RESET = 10'h000;
    localparam logic [3:0] IRQ_MASK_RESET = 4'h0;

    // ********************************
    // synchronised input vector layout
    // ********************************
    localparam int IN_W = 22;
    localparam int IN_ATA_PORT_ENABLE = 0;
    localparam int IN_GATE = 1;
    localparam int IN_DRIVE_READY = 2;
    localparam int IN_BUS_CLASS = 3;
    localparam int IN_BUS_SUPPLY = 4;
    localparam int IN_DRV_SUPPLY = 5;
    localparam int IN_MEDIA_N = 6;
    localparam int IN_GPIO_LSB = 7;
    localparam int IN_TEST_LSB = 17;
    localparam int IN_SCAN = 21;
    localparam logic [21:0] IN_RESET = 22'h000040;

    // ********************************
    // status and event fields
    // ********************************
    localparam int EV_W = 4;
    localparam int EV_MEDIA = 0;
    localparam int EV_BUS_SUPPLY = 1;
    localparam int EV_DRIVE_READY = 2;
    localparam int EV_DRV_SUPPLY = 3;
    localparam int ST_TEST_BIT = 8;

endpackage

// [bcsp_pins.sv]
// control and status pin logic of the usb to ata bridge
`timescale 1ns/1ps

module bcsp_pins #(
    parameter int GPIO_W = 10,
    parameter int ATA_OE_W = 28,
    parameter int FILTER_CYCLES = bcsp_pkg::MEDIA_FILTER_CYCLES,
    parameter int FILTER_CNT_W = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    // avalon-mm slave
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic irq,
    // pins from outside
    input wire logic ata_port_enable,
    input wire logic host_interrupt_gate,
    input wire logic drive_ready_in,
    input wire logic bus_current_class,
    input wire logic bus_supply_present,
    input wire logic drive_supply_present,
    input wire logic media_present_n,
    input wire logic [3:0] fab_test_select,
    input wire logic scan_chain_enable,
    input wire logic [GPIO_W-1:0] general_io_pins_in,
    output logic [GPIO_W-1:0] general_io_pins_out,
    output logic [GPIO_W-1:0] general_io_pins_oe_n,
    output logic low_power_indicator_n_out,
    output logic low_power_indicator_n_oe_n,
    output logic bus_power_granted_n_out,
    output logic bus_power_granted_n_oe_n,
    output logic ready_pullup_enable_out,
    output logic ready_pullup_enable_oe_n,
    // ata engine side
    input wire logic [ATA_OE_W-1:0] ata_core_drive,
    output logic [ATA_OE_W-1:0] ata_pin_oe_n,
    output logic ata_core_run,
    // usb core side
    input wire logic usb_suspend,
    input wire logic [7:0] usb_config_value,
    input wire logic int_in_token,
    input wire logic int_data_pending,
    output logic int_send_data,
    output logic int_send_nak,
    output logic remote_wakeup_req,
    // qualified status toward the rest of the bridge
    output logic drive_accepts_commands,
    output logic vbus_high_current,
    output logic vbus_present,
    output logic drive_supply_ok,
    output logic media_present
);

    // ********************************
    // state
    // ********************************
    typedef struct packed {
        logic [bcsp_pkg::IN_W-1:0] sync1;
        logic [bcsp_pkg::IN_W-1:0] sync2;
        logic [bcsp_pkg::IN_W-1:0] prev;
        logic [FILTER_CNT_W-1:0] filt_cnt;
        logic media_filt_n;
        logic drv_ok;
        logic ack;
        logic [31:0] rdata;
        logic [bcsp_pkg::CTRL_W-1:0] ctrl;
        logic [GPIO_W-1:0] gpio_out;
        logic [GPIO_W-1:0] gpio_dir;
        logic [bcsp_pkg::EV_W-1:0] irq_stat;
        logic [bcsp_pkg::EV_W-1:0] irq_mask;
        logic wake;
        logic int_data;
        logic int_nak;
    } bcsp_state_type;

    bcsp_state_type st;
    bcsp_state_type next_st;

    localparam logic [FILTER_CNT_W-1:0] FILTER_LAST = FILTER_CNT_W'(FILTER_CYCLES - 1);

    // ********************************
    // helpers
    // ********************************
    function automatic logic [31:0] bcsp_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                               input logic [3:0] be);
        logic [31:0] m;
        m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        return (old_v & ~m) | (new_v & m);
    endfunction

    function automatic logic bcsp_hit(input logic [4:0] a, input logic [4:0] off);
        return a == off;
    endfunction

    // ********************************
    // combinational views of state
    // ********************************
    logic ata_port_enable_s;
    logic gate_s;
    logic low_power;
    logic test_mode;
    logic [bcsp_pkg::IN_W-1:0] raw_in;

    assign raw_in = {scan_chain_enable, fab_test_select, general_io_pins_in, media_present_n,
                     drive_supply_present, bus_supply_present, bus_current_class, drive_ready_in,
                     host_interrupt_gate, ata_port_enable};
    assign ata_port_enable_s = st.sync2[bcsp_pkg::IN_ATA_PORT_ENABLE];
    assign gate_s = st.sync2[bcsp_pkg::IN_GATE];
    assign low_power = usb_suspend | st.ctrl[bcsp_pkg::CTRL_LOW_POWER_BIT];
    // reported only, a live test strap means the part is not in normal use
    assign test_mode = (st.sync2[bcsp_pkg::IN_TEST_LSB +: 4] != 4'h0) | st.sync2[bcsp_pkg::IN_SCAN];

    // ********************************
    // next state
    // ********************************
    always_comb begin
        logic [bcsp_pkg::EV_W-1:0] ev;
        logic [bcsp_pkg::EV_W-1:0] clr;
        logic [31:0] rd;
        logic media_new_n;
        logic drv_new;
        logic take;
        ev = '0;
        clr = '0;
        rd = 32'h0000_0000;
        media_new_n = st.media_filt_n;
        take = 1'b0;
        next_st = st;

        // two flop synchronisers, the first stage feeds only the second
        next_st.sync1 = raw_in;
        next_st.sync2 = st.sync1;
        next_st.prev = st.sync2;

        // media filter: a new level must hold for the whole window
        if (st.sync2[bcsp_pkg::IN_MEDIA_N] == st.media_filt_n) begin
            next_st.filt_cnt = '0;
        end else if (st.filt_cnt == FILTER_LAST) begin
            next_st.filt_cnt = '0;
            media_new_n = st.sync2[bcsp_pkg::IN_MEDIA_N];
        end else begin
            next_st.filt_cnt = st.filt_cnt + 1'b1;
        end
        next_st.media_filt_n = media_new_n;

        // one wakeup pulse per accepted transition
        next_st.wake = (media_new_n != st.media_filt_n) & st.ctrl[bcsp_pkg::CTRL_WAKE_EN_BIT];

        // drive supply meaning set by configuration
        drv_new = st.ctrl[bcsp_pkg::CTRL_DRV_FEATURE_BIT] &
                  (st.sync2[bcsp_pkg::IN_DRV_SUPPLY] ^ st.ctrl[bcsp_pkg::CTRL_DRV_POL_BIT]);
        next_st.drv_ok = drv_new;

        // events
        ev[bcsp_pkg::EV_MEDIA] = media_new_n != st.media_filt_n;
        ev[bcsp_pkg::EV_BUS_SUPPLY] = st.sync2[bcsp_pkg::IN_BUS_SUPPLY] != st.prev[bcsp_pkg::IN_BUS_SUPPLY];
        ev[bcsp_pkg::EV_DRIVE_READY] = st.sync2[bcsp_pkg::IN_DRIVE_READY] != st.prev[bcsp_pkg::IN_DRIVE_READY];
        ev[bcsp_pkg::EV_DRV_SUPPLY] = drv_new != st.drv_ok;

        // interrupt pipe: token answered on the next cycle
        next_st.int_data = int_in_token & gate_s & int_data_pending;
        next_st.int_nak = int_in_token & ~(gate_s & int_data_pending);

        // bus slave: one wait cycle, then the answer
        next_st.ack = (avs_read | avs_write) & ~st.ack;
        take = (avs_read | avs_write) & st.ack;
        if ((avs_read | avs_write) & ~st.ack) begin
            if (bcsp_hit(avs_address, bcsp_pkg::CTRL_OFFSET)) begin
                rd[bcsp_pkg::CTRL_W-1:0] = st.ctrl;
            end else if (bcsp_hit(avs_address, bcsp_pkg::STATUS_OFFSET)) begin
                rd[bcsp_pkg::IN_ATA_PORT_ENABLE] = ata_port_enable_s;
                rd[bcsp_pkg::IN_GATE] = gate_s;
                rd[bcsp_pkg::IN_DRIVE_READY] = st.sync2[bcsp_pkg::IN_DRIVE_READY];
                rd[bcsp_pkg::IN_BUS_CLASS] = st.sync2[bcsp_pkg::IN_BUS_CLASS];
                rd[bcsp_pkg::IN_BUS_SUPPLY] = st.sync2[bcsp_pkg::IN_BUS_SUPPLY];
                rd[bcsp_pkg::IN_DRV_SUPPLY] = st.drv_ok;
                rd[bcsp_pkg::IN_MEDIA_N] = st.media_filt_n;
                rd[bcsp_pkg::ST_TEST_BIT] = test_mode;
            end else if (bcsp_hit(avs_address, bcsp_pkg::GPIO_OUT_OFFSET)) begin
                rd[GPIO_W-1:0] = st.gpio_out;
            end else if (bcsp_hit(avs_address, bcsp_pkg::GPIO_DIR_OFFSET)) begin
                rd[GPIO_W-1:0] = st.gpio_dir;
            end else if (bcsp_hit(avs_address, bcsp_pkg::GPIO_IN_OFFSET)) begin
                rd[GPIO_W-1:0] = st.sync2[bcsp_pkg::IN_GPIO_LSB +: GPIO_W];
            end else if (bcsp_hit(avs_address, bcsp_pkg::IRQ_STATUS_OFFSET)) begin
                rd[bcsp_pkg::EV_W-1:0] = st.irq_stat;
            end else if (bcsp_hit(avs_address, bcsp_pkg::IRQ_MASK_OFFSET)) begin
                rd[bcsp_pkg::EV_W-1:0] = st.irq_mask;
            end
            next_st.rdata = rd;
        end

        if (take & avs_write) begin
            if (bcsp_hit(avs_address, bcsp_pkg::CTRL_OFFSET)) begin
                next_st.ctrl = bcsp_merge({28'h0, st.ctrl}, avs_writedata,
                                          avs_byteenable)[bcsp_pkg::CTRL_W-1:0];
            end else if (bcsp_hit(avs_address, bcsp_pkg::GPIO_OUT_OFFSET)) begin
                next_st.gpio_out = bcsp_merge(32'(st.gpio_out), avs_writedata, avs_byteenable)[GPIO_W-1:0];
            end else if (bcsp_hit(avs_address, bcsp_pkg::GPIO_DIR_OFFSET)) begin
                next_st.gpio_dir = bcsp_merge(32'(st.gpio_dir), avs_writedata, avs_byteenable)[GPIO_W-1:0];
            end else if (bcsp_hit(avs_address, bcsp_pkg::IRQ_STATUS_OFFSET)) begin
                clr = avs_writedata[bcsp_pkg::EV_W-1:0] & {bcsp_pkg::EV_W{avs_byteenable[0]}};
            end else if (bcsp_hit(avs_address, bcsp_pkg::IRQ_MASK_OFFSET)) begin
                next_st.irq_mask = bcsp_merge({28'h0, st.irq_mask}, avs_writedata,
                                              avs_byteenable)[bcsp_pkg::EV_W-1:0];
            end
        end

        // a new event beats a clear in the same cycle
        next_st.irq_stat = (st.irq_stat & ~clr) | ev;
    end

    // ********************************
    // registers
    // ********************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st.sync1 <= bcsp_pkg::IN_RESET;
            st.sync2 <= bcsp_pkg::IN_RESET;
            st.prev <= bcsp_pkg::IN_RESET;
            st.filt_cnt <= '0;
            st.media_filt_n <= 1'b1;
            st.drv_ok <= 1'b0;
            st.ack <= 1'b0;
            st.rdata <= 32'h0000_0000;
            st.ctrl <= bcsp_pkg::CTRL_RESET;
            st.gpio_out <= GPIO_W'(bcsp_pkg::GPIO_OUT_RESET);
            st.gpio_dir <= GPIO_W'(bcsp_pkg::GPIO_DIR_RESET);
            st.irq_stat <= '0;
            st.irq_mask <= bcsp_pkg::IRQ_MASK_RESET;
            st.wake <= 1'b0;
            st.int_data <= 1'b0;
            st.int_nak <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    // ********************************
    // bus and interrupt outputs
    // ********************************
    assign avs_waitrequest = (avs_read | avs_write) & ~st.ack;
    assign avs_readdata = st.rdata;
    assign irq = |(st.irq_stat & st.irq_mask);

    // ********************************
    // ata port gating
    // ********************************
    // the synchroniser adds two cycles before the port floats; a sharing host must allow for it
    assign ata_core_run = ata_port_enable_s;
    assign ata_pin_oe_n = ~(ata_core_drive & {ATA_OE_W{ata_port_enable_s}});

    // ready pullup: low in suspend, high otherwise, floated when the port is off
    assign ready_pullup_enable_out = ~usb_suspend;
    assign ready_pullup_enable_oe_n = ~ata_port_enable_s;

    // ********************************
    // open drain indicators
    // ********************************
    assign low_power_indicator_n_out = 1'b0;
    assign low_power_indicator_n_oe_n = ~low_power;
    assign bus_power_granted_n_out = 1'b0;
    assign bus_power_granted_n_oe_n = usb_config_value != 8'h01;

    // ********************************
    // general io
    // ********************************
    genvar gi;
    generate
        for (gi = 0; gi < GPIO_W; gi++) begin : g_gpio
            assign general_io_pins_out[gi] = st.gpio_out[gi];
            assign general_io_pins_oe_n[gi] = ~st.gpio_dir[gi];
        end
    endgenerate

    // ********************************
    // qualified status
    // ********************************
    assign drive_accepts_commands = st.sync2[bcsp_pkg::IN_DRIVE_READY];
    assign vbus_high_current = st.sync2[bcsp_pkg::IN_BUS_CLASS];
    assign vbus_present = st.sync2[bcsp_pkg::IN_BUS_SUPPLY];
    assign drive_supply_ok = st.drv_ok;
    assign media_present = ~st.media_filt_n;
    assign remote_wakeup_req = st.wake;
    assign int_send_data = st.int_data;
    assign int_send_nak = st.int_nak;

endmodule

// [bcsp_pins_chk.sv]
// assertions on the control and status pin block
`timescale 1ns/1ps

module bcsp_pins_chk #(
    parameter int ATA_OE_W = 28,
    parameter int FILTER_CYCLES = 4
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    input wire logic ata_port_enable,
    input wire logic host_interrupt_gate,
    input wire logic drive_ready_in,
    input wire logic bus_supply_present,
    input wire logic media_present_n,
    input wire logic [ATA_OE_W-1:0] ata_core_drive,
    input wire logic [ATA_OE_W-1:0] ata_pin_oe_n,
    input wire logic ata_core_run,
    input wire logic low_power_indicator_n_oe_n,
    input wire logic bus_power_granted_n_oe_n,
    input wire logic ready_pullup_enable_out,
    input wire logic ready_pullup_enable_oe_n,
    input wire logic usb_suspend,
    input wire logic [7:0] usb_config_value,
    input wire logic int_in_token,
    input wire logic int_data_pending,
    input wire logic int_send_data,
    input wire logic int_send_nak,
    input wire logic remote_wakeup_req,
    input wire logic drive_accepts_commands,
    input wire logic vbus_present,
    input wire logic media_present
);
    // ********************************
    // one clock domain, async reset
    // ********************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    one_wait_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus answer late");
    grant_cfg_a: assert property (bus_power_granted_n_oe_n == (usb_config_value != 8'h01))
        else $error("bus power grant wrong");
    suspend_pins_a: assert property (usb_suspend |-> !low_power_indicator_n_oe_n && !ready_pullup_enable_out)
        else $error("suspend pins wrong");
    pullup_float_a: assert property (!ata_port_enable [*3] |-> ready_pullup_enable_oe_n)
        else $error("pullup not floated");
    ata_float_a: assert property (!ata_port_enable [*3] |-> (&ata_pin_oe_n) && !ata_core_run)
        else $error("ata port not floated");
    ata_run_a: assert property (ata_port_enable [*3] |-> ata_core_run && ata_pin_oe_n == ~ata_core_drive)
        else $error("ata port not running");
    gate_nak_a: assert property (!host_interrupt_gate [*3] ##0 int_in_token |=> int_send_nak && !int_send_data)
        else $error("gated token not refused");
    gate_data_a: assert property (host_interrupt_gate [*3] ##0 (int_in_token && int_data_pending) |=> int_send_data)
        else $error("open gate sent no data");
    pipe_cause_a: assert property (int_send_data || int_send_nak |-> $past(int_in_token))
        else $error("pipe answer without token");
    sync_level_a: assert property ($past(rst_n, 2) |-> vbus_present == $past(bus_supply_present, 2)
        && drive_accepts_commands == $past(drive_ready_in, 2)) else $error("level not passed");
    media_stable_a: assert property ($changed(media_present) |-> $past(media_present_n, 4) != media_present
        && $past(media_present_n, FILTER_CYCLES + 2) != media_present) else $error("media change unfiltered");
    wake_cause_a: assert property (remote_wakeup_req |-> $changed(media_present))
        else $error("wakeup without media change");
endmodule

bind bcsp_pins bcsp_pins_chk #(.ATA_OE_W(ATA_OE_W), .FILTER_CYCLES(FILTER_CYCLES)) chk_u (
    .clk, .rst_n, .avs_read, .avs_write, .avs_waitrequest, .ata_port_enable, .host_interrupt_gate,
    .drive_ready_in, .bus_supply_present, .media_present_n, .ata_core_drive, .ata_pin_oe_n, .ata_core_run,
    .low_power_indicator_n_oe_n, .bus_power_granted_n_oe_n, .ready_pullup_enable_out, .ready_pullup_enable_oe_n,
    .usb_suspend, .usb_config_value, .int_in_token, .int_data_pending, .int_send_data, .int_send_nak,
    .remote_wakeup_req, .drive_accepts_commands, .vbus_present, .media_present
);

// [bcsp_board_model.sv]
// board model: media switch with contact chatter and test straps
`timescale 1ns/1ps

module bcsp_board_model (
    input wire logic clk,
    input wire logic want_media,
    input wire logic chatter,
    output logic media_present_n,
    output logic [3:0] fab_test_select,
    output logic scan_chain_enable
);
    assign fab_test_select = 4'h0;
    assign scan_chain_enable = 1'b0;
    initial media_present_n = 1'b1;
    // a line toggling every cycle never looks stable to the filter
    always @(posedge clk) begin
        if (chatter)
            media_present_n <= !media_present_n;
        else
            media_present_n <= !want_media;
    end
endmodule

// [bcsp_pins_bench.sv]
// self-checking bench of the control and status pin block
`timescale 1ns/1ps

module bcsp_pins_bench;
    localparam int FC = 4;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [4:0] avs_address = 5'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic [31:0] pins = 32'h0;
    logic [31:0] seed = 32'h0000d620;
    logic [27:0] ata_core_drive = 28'h0;
    logic [27:0] ata_pin_oe_n;
    logic [9:0] gpio_out, gpio_oe_n;
    logic [7:0] usb_config_value = 8'h00;
    logic [3:0] fab_test_select;
    logic int_in_token = 1'b0;
    logic want_media = 1'b0;
    logic chatter = 1'b0;
    logic avs_waitrequest, irq, media_present_n, scan_chain_enable, lp_oe_n, grant_oe_n, pu_out, pu_oe_n;
    logic ata_run, send_data, send_nak, wake, drv_ok, vbus_hi, vbus_on, drv_rdy, media_on;
    int mismatches = 0;
    int num_checks = 0;
    int wakes = 0;

    bcsp_pins #(.FILTER_CYCLES(FC)) dut_u (
        .clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable(4'hf),
        .avs_readdata, .avs_waitrequest, .irq, .ata_port_enable(pins[0]), .host_interrupt_gate(pins[1]),
        .drive_ready_in(pins[2]), .bus_current_class(pins[3]), .bus_supply_present(pins[4]),
        .drive_supply_present(pins[5]), .media_present_n, .fab_test_select, .scan_chain_enable,
        .general_io_pins_in(pins[15:6]), .general_io_pins_out(gpio_out), .general_io_pins_oe_n(gpio_oe_n),
        .low_power_indicator_n_out(), .low_power_indicator_n_oe_n(lp_oe_n), .bus_power_granted_n_out(),
        .bus_power_granted_n_oe_n(grant_oe_n), .ready_pullup_enable_out(pu_out), .ready_pullup_enable_oe_n(pu_oe_n),
        .ata_core_drive, .ata_pin_oe_n, .ata_core_run(ata_run), .usb_suspend(pins[19]), .usb_config_value,
        .int_in_token, .int_data_pending(pins[24]), .int_send_data(send_data), .int_send_nak(send_nak),
        .remote_wakeup_req(wake), .drive_accepts_commands(drv_rdy), .vbus_high_current(vbus_hi),
        .vbus_present(vbus_on), .drive_supply_ok(drv_ok), .media_present(media_on)
    );
    bcsp_board_model board_u (.clk, .want_media, .chatter, .media_present_n, .fab_test_select, .scan_chain_enable);

    // ********************************
    // clock, helpers and expectations
    // ********************************
    always #5 clk = ~clk;
    always @(posedge clk) if (wake === 1'b1) wakes <= wakes + 1;

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic [31:0] exp_out(logic [31:0] r);
        return {24'h0, r[18:16] != 3'h1, !(r[19] | r[23]), !r[19], !r[0], r[3], r[4], r[2], r[21] & (r[5] ^ r[22])};
    endfunction

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    // holds the request until waitrequest is sampled low, or gives up after 50 cycles and counts a mismatch
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= !wr;
        avs_write <= wr;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (n == 50) mismatches++;
    endtask

    task automatic report_and_stop();
        if (mismatches == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // ********************************
    // scenarios
    // ********************************
    initial begin
        logic [31:0] q;
        logic [31:0] r;
        logic [31:0] s;
        logic [4:0] regs [5];
        regs = '{bcsp_pkg::CTRL_OFFSET, bcsp_pkg::GPIO_OUT_OFFSET, bcsp_pkg::GPIO_DIR_OFFSET,
            bcsp_pkg::IRQ_MASK_OFFSET, 5'h1c};
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        foreach (regs[i]) begin
            bus(1'b0, regs[i], 32'h0, q);
            chk("reset value", 32'h0, q);
        end
        for (int i = 0; i < 16; i++) begin
            r = rnd();
            s = rnd();
            if (i == 0) r[18:16] = 3'h1;
            @(posedge clk);
            pins <= r;
            usb_config_value <= {5'h00, r[18:16]};
            ata_core_drive <= s[27:0];
            bus(1'b1, bcsp_pkg::CTRL_OFFSET, {28'h0, r[23:21], 1'b0}, q);
            bus(1'b1, bcsp_pkg::GPIO_OUT_OFFSET, s, q);
            bus(1'b1, bcsp_pkg::GPIO_DIR_OFFSET, s >> 10, q);
            bus(1'b0, bcsp_pkg::STATUS_OFFSET, 32'h0, q);
            chk("status", {23'h0, 3'h1, r[21] & (r[5] ^ r[22]), r[4:0]}, q);
            bus(1'b0, bcsp_pkg::GPIO_IN_OFFSET, 32'h0, q);
            chk("gpio in", {22'h0, r[15:6]}, q);
            #1;
            chk("gpio drive", {12'h0, ~s[19:10], s[9:0]}, {12'h0, gpio_oe_n, gpio_out});
            chk("ata port", {3'h0, r[0], ~(s[27:0] & {28{r[0]}})}, {3'h0, ata_run, ata_pin_oe_n});
            chk("levels", exp_out(r), {24'h0, grant_oe_n, lp_oe_n, pu_out, pu_oe_n, vbus_hi, vbus_on, drv_rdy, drv_ok});
            @(posedge clk);
            int_in_token <= 1'b1;
            @(posedge clk);
            int_in_token <= 1'b0;
            #1;
            chk("int pipe", {30'h0, r[1] & r[24], !(r[1] & r[24])}, {30'h0, send_data, send_nak});
        end
        @(posedge clk);
        pins <= 32'h1;
        repeat (4) @(posedge clk);
        bus(1'b1, bcsp_pkg::CTRL_OFFSET, 32'h1, q);
        bus(1'b1, bcsp_pkg::IRQ_STATUS_OFFSET, 32'hf, q);
        @(posedge clk);
        want_media <= 1'b1;
        repeat (FC - 1) @(posedge clk);
        want_media <= 1'b0;
        chatter <= 1'b1;
        repeat (8) @(posedge clk);
        chatter <= 1'b0;
        want_media <= 1'b1;
        #1;
        chk("short level", 32'h0, {wakes[30:0], media_on});
        repeat (FC + 6) @(posedge clk);
        #1;
        chk("accepted level", 32'h3, {wakes[30:0], media_on});
        bus(1'b0, bcsp_pkg::IRQ_STATUS_OFFSET, 32'h0, q);
        chk("event status", 32'h1, q);
        chk("masked irq", 32'h0, {31'h0, irq});
        bus(1'b1, bcsp_pkg::IRQ_MASK_OFFSET, 32'h1, q);
        #1;
        chk("raised irq", 32'h1, {31'h0, irq});
        bus(1'b1, bcsp_pkg::IRQ_STATUS_OFFSET, 32'h1, q);
        bus(1'b0, bcsp_pkg::IRQ_STATUS_OFFSET, 32'h0, q);
        chk("cleared irq", 32'h0, q | {31'h0, irq});
        report_and_stop();
    end

    initial begin
        repeat (4000) @(posedge clk);
        mismatches++;
        report_and_stop();
    end
endmodule
